// File: design/sysctl_pkg.sv
// package: constants and state types for the low system control bits
// Overview of operation
// RL1 - parity report bit routes card parity to SERR
// RL2 - bit 3 reserved, always reads zero
// RL3 - bit 2 reads legacy socket voltage selection
// RL4 - hold bit keeps clocks via clock-run line
// RL5 - hold clear lets clocks stop; set never
// RL6 - hold setting acts on every device function
// RL7 - select bit one drives wake onto pin
// RL8 - select zero, ring enable one: ring
// RL9 - both zero: shared pin goes high impedance
// RL10 - low five bits clear only on global reset
// RL11 - wake context clears per wake enable state
// RL12 - writes hit bits 4,1,0 only
package sysctl_pkg;
   // ------------------------------------------------------------------
   // register placement and fields
   // ------------------------------------------------------------------
   localparam int          CFG_AW         = 8;       // config address width
   localparam logic [7:0]  SYSCTL_OFFSET  = 8'h40;   // byte offset of the register
   localparam int          PAR_BIT        = 4;       // card parity report enable
   localparam int          RSVD_BIT       = 3;       // reserved, reads zero
   localparam int          VOLT_BIT       = 2;       // legacy socket voltage
   localparam int          HOLD_BIT       = 1;       // hold clocks running
   localparam int          SEL_BIT        = 0;       // wake pin source select
   localparam logic        FIELD_RST      = 1'b0;    // every low field resets to 0
   // ------------------------------------------------------------------
   // clock-run timing
   // ------------------------------------------------------------------
   localparam int          KEEP_DRIVE_NS  = 8;       // least low drive on the line
   localparam int          CLK_PERIOD_NS  = 4;       // 250 MHz system clock
   // whole cycles rounded up; integer maths keeps the count exact
   localparam int          KEEP_DRIVE_CYC = (KEEP_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0]  KEEP_CNT_INIT  = 4'(KEEP_DRIVE_CYC);
   // ------------------------------------------------------------------
   // state types
   // ------------------------------------------------------------------
   typedef enum logic [0:0] {KEEP_IDLE, KEEP_DRIVE} keep_phase_t;
   typedef struct packed {
      keep_phase_t phase;   // idle or driving the line low
      logic [3:0]  cnt;     // cycles left to drive
      logic        drv;     // clock-run output enable
      logic        stop_ok; // clocks may stop
   } keep_state_t;
   typedef struct packed {
      logic        par_en;  // parity report enable
      logic        volt;    // legacy voltage selection mirror
      logic        hold;    // hold clocks running
      logic        sel;     // wake pin source select
      logic        serr;    // system error request
      logic [31:0] rdata;   // read data
      logic        rvalid;  // read answer strobe
      logic        pme_ctx; // wake context (sticky)
      logic        pin_out; // shared pin level
      logic        pin_oe;  // shared pin enable
   } sc_state_t;
endpackage : sysctl_pkg

// File: design/clkrun_keeper.sv
// module: clock-run line keeper driven by the hold-clocks bit
`timescale 1ns/1ps
module clkrun_keeper
   import sysctl_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // control
   input  wire logic hold,          // hold clocks running
   // clock-run line (low means clock wanted)
   input  wire logic clkrun_in,     // sampled line level
   output logic      clkrun_out,    // always low when driving
   output logic      clkrun_oe,     // high while driving
   // clock stop permission
   output logic      clock_stop_ok  // host and card clocks may stop
);
   keep_state_t cur;       // registered state
   keep_state_t next_cur;  // next state

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   // the host raises the line to ask for a stop; we pull it back low
   always_comb begin
      next_cur         = cur;
      next_cur.stop_ok = !hold;                               // [RL5]
      case (cur.phase)
         KEEP_IDLE: begin
            next_cur.drv = 1'b0;
            if (hold && clkrun_in) begin                      // [RL4]
               next_cur.phase = KEEP_DRIVE;
               next_cur.cnt   = KEEP_CNT_INIT;
               next_cur.drv   = 1'b1;
            end
         end
         KEEP_DRIVE: begin
            // release once the minimum drive is done
            if (cur.cnt <= 4'h1) begin
               next_cur.phase = KEEP_IDLE;
               next_cur.drv   = 1'b0;
            end else begin
               next_cur.cnt = cur.cnt - 4'h1;
            end
         end
         default: begin
            next_cur.phase = KEEP_IDLE;
            next_cur.drv   = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cur <= '{phase: KEEP_IDLE, cnt: 4'h0, drv: 1'b0, stop_ok: 1'b1};
      end else begin
         cur <= next_cur;
      end
   end

   assign clkrun_out    = 1'b0;
   assign clkrun_oe     = cur.drv;
   assign clock_stop_ok = cur.stop_ok;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   chk_keep_drive: assert property (@(posedge sys_clk) disable iff (rst) // [RL4]
      (hold && clkrun_in && cur.phase == KEEP_IDLE) |=> clkrun_oe [*2])
      else $error("clock-run line not held low");
   chk_stop_block: assert property (@(posedge sys_clk) disable iff (rst) // [RL5]
      hold |=> !clock_stop_ok)
      else $error("clock stop allowed while hold set");
endmodule : clkrun_keeper

// File: design/system_control_low_bits.sv
// module: low five bits of the system control register and their logic
`timescale 1ns/1ps
module system_control_low_bits
   import sysctl_pkg::*;
(
   // clock and resets
   input  wire logic              sys_clk,
   input  wire logic              rst,              // global reset
   input  wire logic              host_bus_reset,   // synchronous host reset
   // configuration space access
   input  wire logic [CFG_AW-1:0] cfg_addr,
   input  wire logic              cfg_wr,
   input  wire logic              cfg_rd,
   input  wire logic [3:0]        cfg_be,
   input  wire logic [31:0]       cfg_wdata,
   output logic      [31:0]       cfg_rdata,
   output logic                   cfg_rvalid,
   // parity reporting
   input  wire logic              card_parity_err,  // one-cycle event
   output logic                   serr_req,         // one-cycle SERR request
   // legacy socket power
   input  wire logic              legacy_socket_voltage_sel,
   // clock control
   input  wire logic              clkrun_in,
   output logic                   clkrun_out,
   output logic                   clkrun_oe,
   output logic                   clock_stop_ok,
   output logic                   hold_all_funcs,   // to every function
   // wake / ring indicate
   input  wire logic              pme_en,
   input  wire logic              pme_event,        // one-cycle wake event
   input  wire logic              ring_indicate_out_en,
   input  wire logic              ring_indicate_output,
   output logic                   wake_pin_out,
   output logic                   wake_pin_oe
);
   // every bit of state lives in one struct; the comb block fills a copy
   // and one register stage takes it, so no field can slip past the reset
   sc_state_t cur;       // registered state
   sc_state_t next_cur;  // next state

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   // same decode serves reads and writes
   function automatic logic reg_hit(input logic [CFG_AW-1:0] a);
      reg_hit = (a == SYSCTL_OFFSET[CFG_AW-1:0]);
   endfunction : reg_hit

   logic wr_hit;  // write to this register, low byte enabled
   logic rd_hit;  // read of this register
   assign wr_hit = cfg_wr && reg_hit(cfg_addr) && cfg_be[0];
   assign rd_hit = cfg_rd && reg_hit(cfg_addr);
   // a write with byte lane 0 disabled carries none of these fields and is
   // dropped whole; lanes 1 to 3 hold nothing of this slice

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   // fields hold by default, so only the written, mirrored and event-driven
   // bits need a branch of their own
   always_comb begin
      next_cur = cur;
      // writable bits only; bits 3 and 2 ignore writes
      if (wr_hit) begin                                          // [RL12]
         next_cur.par_en = cfg_wdata[PAR_BIT];
         next_cur.hold   = cfg_wdata[HOLD_BIT];                  // [RL6]
         next_cur.sel    = cfg_wdata[SEL_BIT];
      end
      // host bus reset leaves the low fields alone by design    [RL10]
      // voltage bit only mirrors the socket power logic
      // the mirror stage keeps a changing socket level out of a read in flight
      next_cur.volt = legacy_socket_voltage_sel;                 // [RL3]
      // gate card parity onto the system error request
      // an error with reporting off is dropped, not held for later
      next_cur.serr = card_parity_err && cur.par_en;             // [RL1]
      // wake context: set wins over the host bus reset clear in the same cycle
      if (pme_event) begin
         next_cur.pme_ctx = 1'b1;
      end else if (host_bus_reset && !pme_en) begin              // [RL11]
         next_cur.pme_ctx = 1'b0;
      end
      // read answer, upper bits outside this slice read zero
      // the strobe stands one cycle; rdata keeps its word until the next read
      next_cur.rvalid = rd_hit;
      if (rd_hit) begin
         next_cur.rdata           = 32'h0000_0000;
         next_cur.rdata[PAR_BIT]  = cur.par_en;
         next_cur.rdata[RSVD_BIT] = 1'b0;                        // [RL2]
         next_cur.rdata[VOLT_BIT] = cur.volt;                    // [RL3]
         next_cur.rdata[HOLD_BIT] = cur.hold;
         next_cur.rdata[SEL_BIT]  = cur.sel;
      end
      // shared pin source: wake first, then ring, else released
      if (cur.sel) begin                                         // [RL7]
         // wake context owns the pin, even while ring enable is set
         next_cur.pin_oe  = 1'b1;
         next_cur.pin_out = cur.pme_ctx;
      end else if (ring_indicate_out_en) begin                   // [RL8]
         // ring level passes through one register stage
         next_cur.pin_oe  = 1'b1;
         next_cur.pin_out = ring_indicate_output;
      end else begin                                             // [RL9]
         // released: level parked low so nothing inside floats
         next_cur.pin_oe  = 1'b0;
         next_cur.pin_out = 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   // only the global reset clears the fields                    [RL10]
   // the host bus reset stays out of this process on purpose; the wake
   // context alone reacts to it, inside the comb block
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cur <= '{par_en: FIELD_RST, volt: FIELD_RST, hold: FIELD_RST, sel: FIELD_RST,
                  serr: 1'b0, rdata: 32'h0000_0000, rvalid: 1'b0, pme_ctx: 1'b0,
                  pin_out: 1'b0, pin_oe: 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   // every output below comes straight from a flip-flop, so none glitches
   assign cfg_rdata      = cur.rdata;
   assign cfg_rvalid     = cur.rvalid;
   assign serr_req       = cur.serr;
   assign wake_pin_out   = cur.pin_out;
   assign wake_pin_oe    = cur.pin_oe;
   assign hold_all_funcs = cur.hold;  // one bit shared by all functions [RL6]

   // clock-run keeper follows the hold bit
   // it sees the registered bit, so a write acts one cycle after it lands
   // and clock_stop_ok drops on that same edge
   clkrun_keeper u_keeper (
      .sys_clk       (sys_clk),
      .rst           (rst),
      .hold          (cur.hold),
      .clkrun_in     (clkrun_in),
      .clkrun_out    (clkrun_out),
      .clkrun_oe     (clkrun_oe),
      .clock_stop_ok (clock_stop_ok)
   );

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   // all checks run on the system clock and pause while the global reset is high
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_serr_gate: assert property ( // [RL1]
      serr_req == $past(card_parity_err && cur.par_en))
      else $error("serr request does not follow enabled parity error");
   chk_rsvd_zero: assert property ( // [RL2]
      cfg_rvalid |-> cfg_rdata[RSVD_BIT] == 1'b0)
      else $error("reserved bit read as one");
   chk_volt_read: assert property ( // [RL3]
      rd_hit |=> cfg_rdata[VOLT_BIT] == $past(legacy_socket_voltage_sel, 2))
      else $error("voltage bit does not mirror selection");
   chk_hold_global: assert property ( // [RL6]
      (wr_hit && cfg_wdata[HOLD_BIT]) |=> hold_all_funcs ##1 !clock_stop_ok)
      else $error("hold write not applied globally");
   chk_pin_wake: assert property ( // [RL7]
      cur.sel |=> wake_pin_oe && wake_pin_out == $past(cur.pme_ctx))
      else $error("wake not routed to shared pin");
   chk_pin_ring: assert property ( // [RL8]
      (!cur.sel && ring_indicate_out_en) |=> wake_pin_oe && wake_pin_out == $past(ring_indicate_output))
      else $error("ring indicate not routed to shared pin");
   chk_pin_release: assert property ( // [RL9]
      (!cur.sel && !ring_indicate_out_en) |=> !wake_pin_oe)
      else $error("shared pin driven while both selects clear");
   chk_host_reset_keep: assert property ( // [RL10]
      (host_bus_reset && !wr_hit) |=> $stable({cur.par_en, cur.hold, cur.sel}))
      else $error("host bus reset changed a global-reset field");
   chk_ctx_keep: assert property ( // [RL11]
      (host_bus_reset && pme_en && cur.pme_ctx) |=> cur.pme_ctx)
      else $error("wake context lost while wake enabled");
   chk_ctx_clear: assert property ( // [RL11]
      (host_bus_reset && !pme_en && !pme_event) |=> !cur.pme_ctx)
      else $error("wake context kept with wake disabled");
   chk_write_store: assert property ( // [RL12]
      wr_hit |=> cur.par_en == $past(cfg_wdata[PAR_BIT]) && cur.sel == $past(cfg_wdata[SEL_BIT])
                 && cur.hold == $past(cfg_wdata[HOLD_BIT]))
      else $error("writable bits did not store");

   // ------------------------------------------------------------------
   // field, read, wake context, parity and pin checks
   // ------------------------------------------------------------------
   // bit 2 follows the socket logic only, whatever a write carries
   chk_volt_no_write: assert property ( // [RL12]
      wr_hit |=> cur.volt == $past(legacy_socket_voltage_sel))
      else $error("write reached the voltage mirror");
   // bits above the slice and bit 3 read zero on every answer
   chk_read_answer: assert property ( // [RL2]
      rd_hit |=> cfg_rvalid && cfg_rdata[31:PAR_BIT+1] == '0 && !cfg_rdata[RSVD_BIT])
      else $error("read answer missing or upper bits set");
   // without a write nothing but the global reset moves these fields
   chk_fields_hold: assert property ( // [RL10]
      !wr_hit |=> $stable({cur.par_en, cur.hold, cur.sel}))
      else $error("writable field moved without a write");
   chk_ctx_set: assert property ( // [RL11]
      pme_event |=> cur.pme_ctx)
      else $error("wake event did not set the context");
   chk_serr_quiet: assert property ( // [RL1]
      !cur.par_en |=> !serr_req)
      else $error("serr request with parity reporting off");
   chk_pin_parked: assert property ( // [RL9]
      !wake_pin_oe |-> !wake_pin_out)
      else $error("released pin still shows a level");

   // main scenarios a run should reach
   cov_parity_report: cover property (cur.par_en && card_parity_err ##1 serr_req);
   cov_ring_route:    cover property (!cur.sel && ring_indicate_out_en ##1 wake_pin_oe);
   cov_keep_clock:    cover property (cur.hold && clkrun_in ##1 clkrun_oe);
   cov_ctx_survive:   cover property (pme_en && host_bus_reset && cur.pme_ctx);
   cov_wake_route:    cover property (cur.sel && cur.pme_ctx ##1 wake_pin_out);
endmodule : system_control_low_bits

// File: test/host_clkrun_model.sv
// host side of the clock-run line, with the line's pull-up
`timescale 1ns/1ps
module host_clkrun_model (
   // host intent
   input  wire logic stop_req,    // host wants the clocks to stop
   // device side of the line
   input  wire logic clkrun_out,  // device drive value
   input  wire logic clkrun_oe,   // device drives while high
   // resolved line
   output logic      clkrun_in    // level seen by every party
);
   // --------------------------------------------------------------
   // line resolution
   // --------------------------------------------------------------
   // a device pull-down wins; a released host line floats high by the pull-up
   always_comb begin
      if (clkrun_oe) begin
         clkrun_in = clkrun_out;
      end else begin
         clkrun_in = stop_req;     // low means host still wants clock
      end
   end
endmodule : host_clkrun_model

// File: test/system_control_low_bits_tb.sv
// testbench: register access, parity, clock keep and shared pin
`timescale 1ns/1ps
module system_control_low_bits_tb;
   import sysctl_pkg::*;
   // --------------------------------------------------------------
   // stimulus and observed signals
   // --------------------------------------------------------------
   logic sys_clk = 1'b0, rst = 1'b1, host_bus_reset = 1'b0;
   logic [CFG_AW-1:0] cfg_addr = 8'h00;
   logic cfg_wr = 1'b0, cfg_rd = 1'b0;
   logic [3:0] cfg_be = 4'h0;
   logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
   logic cfg_rvalid, serr_req, clkrun_in, clkrun_out, clkrun_oe, clock_stop_ok, hold_all_funcs;
   logic card_parity_err = 1'b0, volt = 1'b0, stop_req = 1'b0;
   logic pme_en = 1'b0, pme_event = 1'b0, ring_en = 1'b0, ring = 1'b0;
   logic wake_pin_out, wake_pin_oe;
   int   n_fail = 0, num_checks = 0;
   always #2 sys_clk = ~sys_clk;   // 250 MHz
   // --------------------------------------------------------------
   // design and host model
   // --------------------------------------------------------------
   system_control_low_bits dut_u (.sys_clk(sys_clk), .rst(rst), .host_bus_reset(host_bus_reset),
      .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .card_parity_err(card_parity_err),
      .serr_req(serr_req), .legacy_socket_voltage_sel(volt), .clkrun_in(clkrun_in),
      .clkrun_out(clkrun_out), .clkrun_oe(clkrun_oe), .clock_stop_ok(clock_stop_ok),
      .hold_all_funcs(hold_all_funcs), .pme_en(pme_en), .pme_event(pme_event),
      .ring_indicate_out_en(ring_en), .ring_indicate_output(ring),
      .wake_pin_out(wake_pin_out), .wake_pin_oe(wake_pin_oe));
   host_clkrun_model host_u (.stop_req(stop_req), .clkrun_out(clkrun_out), .clkrun_oe(clkrun_oe),
      .clkrun_in(clkrun_in));
   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // wait n edges, then settle 1 ns so registered outputs have landed
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge sys_clk);
      cfg_addr <= a; cfg_be <= be; cfg_wdata <= d; cfg_wr <= 1'b1;
      @(posedge sys_clk);
      cfg_wr <= 1'b0;
   endtask : wr
   // read answer is a one-cycle strobe right after the taking edge
   task automatic rd(input logic [31:0] exp);
      @(posedge sys_clk);
      cfg_addr <= SYSCTL_OFFSET; cfg_rd <= 1'b1;
      @(posedge sys_clk);
      cfg_rd <= 1'b0;
      #1;
      chk({31'h0, cfg_rvalid}, 32'h1);
      chk(cfg_rdata, exp);
   endtask : rd
   task automatic results;
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   // watchdog: the sequence needs well under 300 cycles
   initial begin
      #20000;
      n_fail++;
      results();
   end
   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      rd(32'h0);
      chk({31'h0, clock_stop_ok}, 32'h1);
      volt <= 1'b1;
      wr(SYSCTL_OFFSET, 4'hF, 32'hFFFF_FFFF);
      rd(32'h17);
      // wrong address and missing byte enable must both be ignored
      wr(8'h44, 4'hF, 32'h0);
      wr(SYSCTL_OFFSET, 4'hE, 32'h0);
      rd(32'h17);
      chk({31'h0, hold_all_funcs}, 32'h1);
      chk({31'h0, clock_stop_ok}, 32'h0);
      @(posedge sys_clk) card_parity_err <= 1'b1;
      @(posedge sys_clk) card_parity_err <= 1'b0;
      #1 chk({31'h0, serr_req}, 32'h1);
      // host releases the line; device pulls it low for two cycles
      @(posedge sys_clk) stop_req <= 1'b1;
      step(1);
      chk({31'h0, clkrun_oe}, 32'h1);
      chk({31'h0, clkrun_out}, 32'h0);
      step(1);
      chk({31'h0, clkrun_oe}, 32'h1);
      step(1);
      chk({31'h0, clkrun_oe}, 32'h0);
      stop_req <= 1'b0;
      wr(SYSCTL_OFFSET, 4'h1, 32'h0);
      step(2);
      chk({30'h0, clock_stop_ok, hold_all_funcs}, 32'h2);
      @(posedge sys_clk) begin
         stop_req <= 1'b1;
         card_parity_err <= 1'b1;
      end
      @(posedge sys_clk) card_parity_err <= 1'b0;
      #1 chk({31'h0, serr_req}, 32'h0);
      step(3);
      chk({31'h0, clkrun_oe}, 32'h0);
      stop_req <= 1'b0;
      // shared pin: released, then ring routed, then wake routed
      step(2);
      chk({30'h0, wake_pin_oe, wake_pin_out}, 32'h0);
      ring_en <= 1'b1; ring <= 1'b1;
      step(2);
      chk({30'h0, wake_pin_oe, wake_pin_out}, 32'h3);
      ring <= 1'b0;
      step(2);
      chk({30'h0, wake_pin_oe, wake_pin_out}, 32'h2);
      wr(SYSCTL_OFFSET, 4'h1, 32'h1);
      @(posedge sys_clk) pme_event <= 1'b1;
      @(posedge sys_clk) pme_event <= 1'b0;
      step(2);
      chk({30'h0, wake_pin_oe, wake_pin_out}, 32'h3);
      // host reset keeps the low fields and, with wake enabled, the context
      pme_en <= 1'b1; host_bus_reset <= 1'b1;
      @(posedge sys_clk) host_bus_reset <= 1'b0;
      rd(32'h5);
      step(1);
      chk({31'h0, wake_pin_out}, 32'h1);
      pme_en <= 1'b0; host_bus_reset <= 1'b1;
      @(posedge sys_clk) host_bus_reset <= 1'b0;
      step(2);
      chk({30'h0, wake_pin_oe, wake_pin_out}, 32'h2);
      wr(SYSCTL_OFFSET, 4'h1, 32'h13);
      @(posedge sys_clk) rst <= 1'b1;
      @(posedge sys_clk) rst <= 1'b0;
      rd(32'h4);
      chk({30'h0, clock_stop_ok, hold_all_funcs}, 32'h2);
      chk({30'h0, wake_pin_oe, wake_pin_out}, 32'h2);
      results();
   end
endmodule : system_control_low_bits_tb
